// ==== rtl/radio_spi_slave_host_port.sv ====
// Purpose: serial slave port and control pins of a radio transceiver
// Assumes: host clock is a second domain, select low frames a transfer
// Notes: fifo and top share this file; all sync resets on core side
`timescale 1ns/10ps

// ---------------------------------------------------------------
// byte fifo
// ---------------------------------------------------------------
module radio_byte_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // fill side
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [WIDTH-1:0] wr_data_i,
  // drain side
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [WIDTH-1:0] rd_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } fifo_state_t;

  fifo_state_t s_q;
  fifo_state_t s_d;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic push;
  logic pop;

  // honest flags from the occupancy count
  assign wr_ready_o = s_q.count != (AW+1)'(DEPTH);
  assign rd_valid_o = s_q.count != '0;
  assign rd_data_o = mem_q[s_q.rd_ptr];
  assign push = wr_valid_i && wr_ready_o;
  assign pop = rd_valid_o && rd_ready_i;

  // pointer and count update
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wr_ptr = (s_q.wr_ptr == AW'(DEPTH - 1)) ? '0 : s_q.wr_ptr + 1'b1;
    end
    if (pop) begin
      s_d.rd_ptr = (s_q.rd_ptr == AW'(DEPTH - 1)) ? '0 : s_q.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      s_d.count = s_q.count + 1'b1;
    end else if (pop && !push) begin
      s_d.count = s_q.count - 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // storage, no reset needed
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_q[s_q.wr_ptr] <= wr_data_i;
    end
  end

endmodule : radio_byte_fifo

// ---------------------------------------------------------------
// top: serial slave and control pins
// ---------------------------------------------------------------
module radio_spi_slave_host_port #(
  parameter int unsigned DEPTH = radio_spi_pkg::FIFO_DEPTH
) (
  // core clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // serial link pins
  input wire logic serial_shift_clock_i,
  input wire logic spi_select_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  // control pins
  input wire logic chip_reset_n_i,
  input wire logic radio_sequence_trigger_i,
  input wire logic wake_request_n_i,
  output logic host_clock_out_o,
  output logic out_of_idle_flag_pin_o,
  output logic crc_valid_flag_pin_o,
  // configuration and radio status
  input wire logic seq_tx_sel_i,
  input wire logic sleep_req_i,
  input wire logic sleep_hibernate_i,
  input wire logic seq_done_i,
  input wire logic [2:0] host_clock_out_sel_i,
  input wire logic host_clock_out_sel_we_i,
  input wire logic gpio_alt_en_i,
  input wire logic crc_valid_i,
  input wire logic out_of_idle_flag_pin_out_i,
  input wire logic crc_valid_flag_pin_out_i,
  output radio_spi_pkg::mode_t mode_o,
  // received header and write bytes
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic rx_header_o,
  output logic [7:0] rx_data_o,
  output logic rx_overrun_o,
  input wire logic rx_overrun_clr_i,
  // read data supply
  input wire logic tx_load_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_full_o,
  output logic tx_req_o,
  // transaction status
  output logic frame_done_o,
  output logic frame_short_o
);

  // -------------------------------------------------------------
  // link domain, serial clock
  // -------------------------------------------------------------
  typedef struct packed {
    logic [2:0] bit_cnt;
    logic [6:0] shift;
    logic hdr_done;
    logic rd;
  } link_state_t;

  link_state_t l_q;
  link_state_t l_d;
  logic link_rst;
  logic chip_off;
  logic [8:0] rx_word_q;
  logic rx_tgl_q;
  logic [7:0] tx_shift_q;
  logic tx_tgl_q;
  logic miso_q;
  logic [7:0] tx_hold_q;
  logic byte_end;

  // frame state clears whenever select is high
  assign chip_off = !chip_reset_n_i;
  assign link_rst = spi_select_n_i || chip_off;
  assign byte_end = l_q.bit_cnt == radio_spi_pkg::LAST_BIT;

  // bit counting and header capture
  always_comb begin
    l_d = l_q;
    l_d.bit_cnt = l_q.bit_cnt + 3'h1;
    l_d.shift = {l_q.shift[5:0], mosi_i}; // msb first
    if (byte_end && !l_q.hdr_done) begin
      l_d.hdr_done = 1'b1;
      l_d.rd = l_q.shift[radio_spi_pkg::HDR_RD_BIT-1];
    end
  end

  always_ff @(posedge serial_shift_clock_i or posedge link_rst) begin
    if (link_rst) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // completed header or write byte, flagged by a toggle
  always_ff @(posedge serial_shift_clock_i or posedge chip_off) begin
    if (chip_off) begin
      rx_word_q <= '0;
      rx_tgl_q <= 1'b0;
    end else if (!spi_select_n_i && byte_end
                 && !(l_q.hdr_done && l_q.rd)) begin
      rx_word_q <= {!l_q.hdr_done, l_q.shift, mosi_i};
      rx_tgl_q <= !rx_tgl_q;
    end
  end

  // read byte counts as taken once the host clocks its first bit
  always_ff @(posedge serial_shift_clock_i or posedge chip_off) begin
    if (chip_off) begin
      tx_tgl_q <= 1'b0;
    end else if (!spi_select_n_i && l_q.hdr_done && l_q.rd
                 && l_q.bit_cnt == 3'h0) begin
      tx_tgl_q <= !tx_tgl_q;
    end
  end

  // read data changes on falling edge, first bit after each byte
  always_ff @(negedge serial_shift_clock_i or posedge chip_off) begin
    if (chip_off) begin
      tx_shift_q <= '0;
    end else if (!spi_select_n_i && l_q.hdr_done && l_q.rd
                 && l_q.bit_cnt == 3'h0) begin
      tx_shift_q <= tx_hold_q;
    end else begin
      tx_shift_q <= {tx_shift_q[6:0], 1'b0};
    end
  end

  // miso idles low outside read data bursts
  always_ff @(negedge serial_shift_clock_i or posedge link_rst) begin
    if (link_rst) begin
      miso_q <= 1'b0;
    end else if (l_q.hdr_done && l_q.rd) begin
      miso_q <= (l_q.bit_cnt == 3'h0) ? tx_hold_q[7] : tx_shift_q[6];
    end else begin
      miso_q <= 1'b0;
    end
  end

  assign miso_o = miso_q;

  // -------------------------------------------------------------
  // core domain
  // -------------------------------------------------------------
  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic trig_s1;
    logic trig_s2;
    logic trig_q;
    logic wake_s1;
    logic wake_s2;
    logic sel_s1;
    logic sel_s2;
    logic sel_q;
    logic rxt_s1;
    logic rxt_s2;
    logic rxt_q;
    logic txt_s1;
    logic txt_s2;
    logic txt_q;
    logic pend_valid;
    logic [8:0] pend_word;
    logic overrun;
    logic [7:0] tx_hold;
    logic tx_full;
    logic tx_req;
    logic out_valid;
    logic [8:0] out_word;
    logic [1:0] bursts;
    logic frame_done;
    logic frame_short;
    radio_spi_pkg::mode_t mode;
    logic [2:0] host_clock_out_sel;
    logic [11:0] host_clock_out_cnt;
    logic host_clock_out;
    logic pin1;
    logic pin2;
  } core_state_t;

  localparam core_state_t CORE_RST = '{
    sel_s1: 1'b1, sel_s2: 1'b1, sel_q: 1'b1,
    wake_s1: 1'b1, wake_s2: 1'b1,
    mode: radio_spi_pkg::MODE_OFF,
    host_clock_out_sel: radio_spi_pkg::HOST_CLOCK_OUT_SEL_RST,
    default: '0};

  core_state_t c_q;
  core_state_t c_d;
  logic fifo_wr_ready;
  logic fifo_rd_valid;
  logic fifo_rd_ready;
  logic [8:0] fifo_rd_data;
  logic rx_ev;
  logic tx_ev;
  logic [1:0] bursts_nx;

  assign tx_hold_q = c_q.tx_hold; // stable while link reads it
  assign rx_ev = c_q.rxt_s2 ^ c_q.rxt_q;
  assign tx_ev = c_q.txt_s2 ^ c_q.txt_q;
  assign fifo_rd_ready = !c_q.out_valid || rx_ready_i;

  // received bytes pass through the fifo
  radio_byte_fifo #(
    .WIDTH(radio_spi_pkg::RX_W),
    .DEPTH(DEPTH)
  ) u_rx_fifo (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .wr_valid_i(c_q.pend_valid),
    .wr_ready_o(fifo_wr_ready),
    .wr_data_i(c_q.pend_word),
    .rd_valid_o(fifo_rd_valid),
    .rd_ready_i(fifo_rd_ready),
    .rd_data_o(fifo_rd_data)
  );

  // next core state
  always_comb begin
    bursts_nx = c_q.bursts;
    c_d = c_q;
    // two-stage synchronisers for pins and toggles
    c_d.rst_s1 = chip_reset_n_i;
    c_d.rst_s2 = c_q.rst_s1;
    c_d.trig_s1 = radio_sequence_trigger_i;
    c_d.trig_s2 = c_q.trig_s1;
    c_d.trig_q = c_q.trig_s2;
    c_d.wake_s1 = wake_request_n_i;
    c_d.wake_s2 = c_q.wake_s1;
    c_d.sel_s1 = spi_select_n_i;
    c_d.sel_s2 = c_q.sel_s1;
    c_d.sel_q = c_q.sel_s2;
    c_d.rxt_s1 = rx_tgl_q;
    c_d.rxt_s2 = c_q.rxt_s1;
    c_d.rxt_q = c_q.rxt_s2;
    c_d.txt_s1 = tx_tgl_q;
    c_d.txt_s2 = c_q.txt_s1;
    c_d.txt_q = c_q.txt_s2;
    // pending byte waits while the fifo is full
    if (c_q.pend_valid && fifo_wr_ready) begin
      c_d.pend_valid = 1'b0;
    end
    // clear first so that a new overrun in the same cycle wins
    if (rx_overrun_clr_i) begin
      c_d.overrun = 1'b0;
    end
    if (rx_ev) begin
      if (c_d.pend_valid) begin
        c_d.overrun = 1'b1;
      end else begin
        c_d.pend_valid = 1'b1;
        c_d.pend_word = rx_word_q;
      end
    end
    // registered output stage
    if (rx_ready_i) begin
      c_d.out_valid = 1'b0;
    end
    if (fifo_rd_valid && fifo_rd_ready) begin
      c_d.out_valid = 1'b1;
      c_d.out_word = fifo_rd_data;
    end
    // read data hand-off, load wins over take
    c_d.tx_req = tx_ev;
    if (tx_ev) begin
      c_d.tx_full = 1'b0;
    end
    if (tx_load_i) begin
      c_d.tx_full = 1'b1;
      c_d.tx_hold = tx_data_i;
    end
    // burst count and frame end
    if ((rx_ev || tx_ev) && c_q.bursts != radio_spi_pkg::BURST_SAT) begin
      bursts_nx = c_q.bursts + 2'h1;
    end
    c_d.bursts = bursts_nx;
    c_d.frame_done = 1'b0;
    c_d.frame_short = 1'b0;
    if (c_q.sel_s2 && !c_q.sel_q) begin
      c_d.frame_done = 1'b1;
      c_d.frame_short = 32'(bursts_nx) < radio_spi_pkg::MIN_BURSTS;
      c_d.bursts = '0;
    end
    // mode sequencing
    case (c_q.mode)
      radio_spi_pkg::MODE_OFF: begin
        c_d.mode = radio_spi_pkg::MODE_IDLE;
      end
      radio_spi_pkg::MODE_IDLE: begin
        if (c_q.trig_s2 && !c_q.trig_q) begin
          c_d.mode = seq_tx_sel_i ? radio_spi_pkg::MODE_TX
                                  : radio_spi_pkg::MODE_RX;
        end else if (sleep_req_i) begin
          c_d.mode = sleep_hibernate_i ? radio_spi_pkg::MODE_HIBERNATE
                                       : radio_spi_pkg::MODE_DOZE;
        end
      end
      radio_spi_pkg::MODE_DOZE, radio_spi_pkg::MODE_HIBERNATE: begin
        if (!c_q.wake_s2) begin
          c_d.mode = radio_spi_pkg::MODE_IDLE;
        end
      end
      radio_spi_pkg::MODE_RX, radio_spi_pkg::MODE_TX: begin
        if (!c_q.trig_s2 || seq_done_i) begin
          c_d.mode = radio_spi_pkg::MODE_IDLE;
        end
      end
      default: begin
        c_d.mode = radio_spi_pkg::MODE_IDLE;
      end
    endcase
    // host clock divider
    if (host_clock_out_sel_we_i) begin
      c_d.host_clock_out_sel = host_clock_out_sel_i;
      c_d.host_clock_out_cnt = '0;
    end else if (c_q.mode == radio_spi_pkg::MODE_OFF
                 || c_q.mode == radio_spi_pkg::MODE_HIBERNATE) begin
      c_d.host_clock_out_cnt = '0;
      c_d.host_clock_out = 1'b0;
    end else if (c_q.host_clock_out_cnt
                 >= radio_spi_pkg::HOST_CLOCK_OUT_HALF[c_q.host_clock_out_sel] - 12'h001) begin
      c_d.host_clock_out_cnt = '0;
      c_d.host_clock_out = !c_q.host_clock_out;
    end else begin
      c_d.host_clock_out_cnt = c_q.host_clock_out_cnt + 12'h001;
    end
    // alternate pin functions
    c_d.pin1 = gpio_alt_en_i ? (c_q.mode != radio_spi_pkg::MODE_IDLE)
                             : out_of_idle_flag_pin_out_i;
    c_d.pin2 = gpio_alt_en_i ? crc_valid_i : crc_valid_flag_pin_out_i;
    // hard reset pin holds control and status state at defaults; data words and pins one and two keep updating
    if (!c_q.rst_s2) begin
      c_d.pend_valid = 1'b0;
      c_d.overrun = 1'b0;
      c_d.tx_full = 1'b0;
      c_d.tx_req = 1'b0;
      c_d.out_valid = 1'b0;
      c_d.bursts = '0;
      c_d.frame_done = 1'b0;
      c_d.frame_short = 1'b0;
      c_d.mode = radio_spi_pkg::MODE_OFF;
      c_d.host_clock_out_sel = radio_spi_pkg::HOST_CLOCK_OUT_SEL_RST;
      c_d.host_clock_out_cnt = '0;
      c_d.host_clock_out = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      c_q <= CORE_RST;
    end else begin
      c_q <= c_d;
    end
  end

  // outputs straight from flops
  assign mode_o = c_q.mode;
  assign host_clock_out_o = c_q.host_clock_out;
  assign out_of_idle_flag_pin_o = c_q.pin1;
  assign crc_valid_flag_pin_o = c_q.pin2;
  assign rx_valid_o = c_q.out_valid;
  assign rx_header_o = c_q.out_word[8];
  assign rx_data_o = c_q.out_word[7:0];
  assign rx_overrun_o = c_q.overrun;
  assign tx_full_o = c_q.tx_full;
  assign tx_req_o = c_q.tx_req;
  assign frame_done_o = c_q.frame_done;
  assign frame_short_o = c_q.frame_short;

endmodule : radio_spi_slave_host_port

// ==== rtl/radio_spi_pkg.sv ====
// Purpose: shared constants and types of the radio host port
// Assumes: core clock of 100 MHz, byte-wide serial bursts
// Notes: clock-out half periods derive from the core rate
package radio_spi_pkg;

  // -------------------------------------------------------------
  // serial framing
  // -------------------------------------------------------------
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned HDR_RD_BIT = 7; // header read flag
  localparam int unsigned MIN_BURSTS = 3;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [1:0] BURST_SAT = 2'h3;

  // -------------------------------------------------------------
  // buffering
  // -------------------------------------------------------------
  localparam int unsigned RX_W = BYTE_W + 1; // {is_header, byte}
  localparam int unsigned FIFO_DEPTH = 16;

  // -------------------------------------------------------------
  // host clock output
  // -------------------------------------------------------------
  localparam int unsigned CORE_HZ = 100_000_000;
  localparam int unsigned CNT_W = 12;
  localparam int unsigned HOST_CLOCK_OUT_HZ [8] = '{16_000_000, 8_000_000,
    4_000_000, 2_000_000, 1_000_000, 62_500, 32_786, 16_393};
  localparam logic [11:0] HOST_CLOCK_OUT_HALF [8] = '{
    12'(CORE_HZ / (2 * HOST_CLOCK_OUT_HZ[0])), 12'(CORE_HZ / (2 * HOST_CLOCK_OUT_HZ[1])),
    12'(CORE_HZ / (2 * HOST_CLOCK_OUT_HZ[2])), 12'(CORE_HZ / (2 * HOST_CLOCK_OUT_HZ[3])),
    12'(CORE_HZ / (2 * HOST_CLOCK_OUT_HZ[4])), 12'(CORE_HZ / (2 * HOST_CLOCK_OUT_HZ[5])),
    12'(CORE_HZ / (2 * HOST_CLOCK_OUT_HZ[6])), 12'(CORE_HZ / (2 * HOST_CLOCK_OUT_HZ[7]))};
  localparam logic [2:0] HOST_CLOCK_OUT_SEL_RST = 3'h6; // about 32.786 kHz

  // -------------------------------------------------------------
  // operating modes
  // -------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_OFF,
    MODE_IDLE,
    MODE_DOZE,
    MODE_HIBERNATE,
    MODE_RX,
    MODE_TX
  } mode_t;

endpackage : radio_spi_pkg

// ==== sim/radio_port_sva.sv ====
// Purpose: temporal checks on the radio host port pins
// Assumes: one core clock domain, sync active-high reset
// Notes: bound to the top module at the foot of this file
`timescale 1ns/10ps
module radio_port_sva (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // serial and control pins
  input wire logic spi_select_n_i,
  input wire logic miso_o,
  input wire logic chip_reset_n_i,
  input wire logic radio_sequence_trigger_i,
  input wire logic wake_request_n_i,
  input wire logic host_clock_out_o,
  input wire logic out_of_idle_flag_pin_o,
  input wire logic crc_valid_flag_pin_o,
  // configuration and status
  input wire logic seq_tx_sel_i,
  input wire logic [2:0] host_clock_out_sel_i,
  input wire logic host_clock_out_sel_we_i,
  input wire logic gpio_alt_en_i,
  input wire logic crc_valid_i,
  input wire logic out_of_idle_flag_pin_out_i,
  input wire logic crc_valid_flag_pin_out_i,
  input wire radio_spi_pkg::mode_t mode_o,
  input wire logic frame_done_o,
  input wire logic frame_short_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  // --------------------------------------------------------
  // clock-out half period monitor
  // --------------------------------------------------------
  typedef struct packed {
    logic lvl;
    logic arm;
    logic [11:0] cnt;
    logic [2:0] sel;
  } mon_t;
  mon_t mon_q;
  mon_t mon_d;
  logic flip;
  logic stop;
  assign flip = host_clock_out_o != mon_q.lvl;
  assign stop = mode_o == radio_spi_pkg::MODE_HIBERNATE || !chip_reset_n_i;
  // level, cycles since last edge, selected rate
  always_comb begin
    mon_d = mon_q;
    mon_d.lvl = host_clock_out_o;
    mon_d.cnt = flip ? 12'h001 : mon_q.cnt + 12'h001;
    mon_d.arm = flip | mon_q.arm;
    if (host_clock_out_sel_we_i) mon_d.sel = host_clock_out_sel_i;
    if (sys_rst_i | host_clock_out_sel_we_i | stop) mon_d.arm = 1'b0;
    if (sys_rst_i | !chip_reset_n_i) mon_d.sel = radio_spi_pkg::HOST_CLOCK_OUT_SEL_RST;
  end
  always_ff @(posedge core_clk_i) mon_q <= mon_d;

  // --------------------------------------------------------
  // properties
  // --------------------------------------------------------
  property p_host_clock_out;
    flip && mon_q.arm |-> mon_q.cnt == radio_spi_pkg::HOST_CLOCK_OUT_HALF[mon_q.sel];
  endproperty
  a_host_clock_out: assert property (p_host_clock_out) else $error("clock out period");
  property p_off;
    !chip_reset_n_i [*5] |->
      mode_o == radio_spi_pkg::MODE_OFF && !host_clock_out_o;
  endproperty
  a_off: assert property (p_off) else $error("off mode lost");
  property p_go;
    $rose(radio_sequence_trigger_i) && mode_o == radio_spi_pkg::MODE_IDLE
      ##1 radio_sequence_trigger_i [*7] |-> mode_o == (seq_tx_sel_i ?
      radio_spi_pkg::MODE_TX : radio_spi_pkg::MODE_RX);
  endproperty
  a_go: assert property (p_go) else $error("sequence not started");
  property p_low;
    !radio_sequence_trigger_i [*8] |->
      mode_o != radio_spi_pkg::MODE_RX && mode_o != radio_spi_pkg::MODE_TX;
  endproperty
  a_low: assert property (p_low) else $error("idle not forced");
  property p_wake;
    (!wake_request_n_i && chip_reset_n_i) [*8] |->
      mode_o != radio_spi_pkg::MODE_DOZE &&
      mode_o != radio_spi_pkg::MODE_HIBERNATE;
  endproperty
  a_wake: assert property (p_wake) else $error("wake ignored");
  property p_pin1;
    ($stable({gpio_alt_en_i, mode_o, out_of_idle_flag_pin_out_i}) && chip_reset_n_i &&
      mode_o != radio_spi_pkg::MODE_OFF) [*3] |->
      out_of_idle_flag_pin_o == (gpio_alt_en_i ?
      mode_o != radio_spi_pkg::MODE_IDLE : out_of_idle_flag_pin_out_i);
  endproperty
  a_pin1: assert property (p_pin1) else $error("pin one wrong");
  property p_pin2;
    ($stable({gpio_alt_en_i, crc_valid_i, crc_valid_flag_pin_out_i}) && chip_reset_n_i &&
      mode_o != radio_spi_pkg::MODE_OFF) [*3] |->
      crc_valid_flag_pin_o == (gpio_alt_en_i ? crc_valid_i : crc_valid_flag_pin_out_i);
  endproperty
  a_pin2: assert property (p_pin2) else $error("pin two wrong");
  property p_miso;
    spi_select_n_i [*2] |-> !miso_o;
  endproperty
  a_miso: assert property (p_miso) else $error("miso driven idle");
  property p_done;
    $rose(spi_select_n_i) && chip_reset_n_i |-> ##[1:8] frame_done_o;
  endproperty
  a_done: assert property (p_done) else $error("frame end missed");
  c_tx: cover property (mode_o == radio_spi_pkg::MODE_TX);
  c_hib: cover property (mode_o == radio_spi_pkg::MODE_HIBERNATE);
  c_short: cover property (frame_short_o);
endmodule : radio_port_sva

bind radio_spi_slave_host_port radio_port_sva u_sva (
  .core_clk_i, .sys_rst_i, .spi_select_n_i, .miso_o, .chip_reset_n_i,
  .radio_sequence_trigger_i, .wake_request_n_i, .host_clock_out_o,
  .out_of_idle_flag_pin_o, .crc_valid_flag_pin_o, .seq_tx_sel_i,
  .host_clock_out_sel_i, .host_clock_out_sel_we_i, .gpio_alt_en_i, .crc_valid_i, .out_of_idle_flag_pin_out_i,
  .crc_valid_flag_pin_out_i, .mode_o, .frame_done_o, .frame_short_o
);

// ==== sim/spi_host_model.sv ====
// Purpose: serial host master driving the port
// Assumes: clock idles low, 30 ns period within frames
// Notes: mosi shows inverted last bit when not meaningful
`timescale 1ns/10ps
module spi_host_model (
  // serial pins
  output logic sclk_o,
  output logic sel_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  // idle levels at start
  initial begin
    sclk_o = 1'b0;
    sel_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  task automatic open_frame();
    #7 sel_n_o = 1'b0;
    #30;
  endtask : open_frame
  // one byte, msb first, optional slow gap before it
  task automatic burst(input logic [7:0] tx, input bit rd, input int gap,
                       output logic [7:0] rx);
    #(gap);
    for (int i = 7; i >= 0; i--) begin
      mosi_o = rd ? ~mosi_o : tx[i];
      #15 sclk_o = 1'b1;
      rx[i] = miso_i;
      #15 sclk_o = 1'b0;
    end
    mosi_o = ~mosi_o;
  endtask : burst
  task automatic close_frame();
    #30 sel_n_o = 1'b1;
  endtask : close_frame
endmodule : spi_host_model

// ==== sim/radio_spi_slave_host_port_tb.sv ====
// Purpose: self-checking bench of the radio host port
// Assumes: host model on the link, 100 MHz core clock
// Notes: queues model the rx fifo and the read byte supply
`timescale 1ns/10ps
module radio_spi_slave_host_port_tb;
  // --------------------------------------------------------
  // pins and model state
  // --------------------------------------------------------
  localparam int DEPTH = 16;
  localparam int HZ [8] = '{16000000, 8000000, 4000000, 2000000,
    1000000, 62500, 32786, 16393};
  logic core_clk_i, serial_shift_clock_i, spi_select_n_i, mosi_i, miso_o;
  logic sys_rst_i = 1'b1, chip_reset_n_i = 1'b0, wake_request_n_i = 1'b1;
  logic radio_sequence_trigger_i = 1'b0, seq_tx_sel_i = 1'b0;
  logic sleep_req_i = 1'b0, sleep_hibernate_i = 1'b0, seq_done_i = 1'b0;
  logic [2:0] host_clock_out_sel_i = 3'h6;
  logic host_clock_out_sel_we_i = 1'b0, gpio_alt_en_i = 1'b0, crc_valid_i = 1'b0;
  logic out_of_idle_flag_pin_out_i = 1'b0, crc_valid_flag_pin_out_i = 1'b0, rx_ready_i = 1'b1;
  logic rx_overrun_clr_i = 1'b0, tx_load_i = 1'b0, hold = 1'b0;
  logic [7:0] tx_data_i = 8'h00;
  logic [7:0] rx_data_o;
  logic host_clock_out_o, out_of_idle_flag_pin_o, crc_valid_flag_pin_o;
  logic rx_valid_o, rx_header_o, rx_overrun_o, tx_full_o, tx_req_o;
  logic frame_done_o, frame_short_o, exp_ovr = 1'b0;
  radio_spi_pkg::mode_t mode_o;
  int seed = 66, err_total = 0, samples_checked = 0, cyc = 0;
  logic [8:0] expq [$];
  logic [7:0] txq [$];

  radio_spi_slave_host_port #(.DEPTH(DEPTH)) uut (
    .core_clk_i, .sys_rst_i, .serial_shift_clock_i, .spi_select_n_i,
    .mosi_i, .miso_o, .chip_reset_n_i, .radio_sequence_trigger_i,
    .wake_request_n_i, .host_clock_out_o, .out_of_idle_flag_pin_o,
    .crc_valid_flag_pin_o, .seq_tx_sel_i, .sleep_req_i, .sleep_hibernate_i,
    .seq_done_i, .host_clock_out_sel_i, .host_clock_out_sel_we_i, .gpio_alt_en_i, .crc_valid_i,
    .out_of_idle_flag_pin_out_i, .crc_valid_flag_pin_out_i, .mode_o, .rx_valid_o, .rx_ready_i,
    .rx_header_o, .rx_data_o, .rx_overrun_o, .rx_overrun_clr_i, .tx_load_i,
    .tx_data_i, .tx_full_o, .tx_req_o, .frame_done_o, .frame_short_o
  );
  spi_host_model host (
    .sclk_o(serial_shift_clock_i), .sel_n_o(spi_select_n_i),
    .mosi_o(mosi_i), .miso_i(miso_o)
  );

  // --------------------------------------------------------
  // clock, timeout and background drivers
  // --------------------------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      finish_test();
    end
  end
  // random status levels and stalls on the byte output
  always @(posedge core_clk_i) begin
    #1;
    if ($random(seed) % 4 == 0)
      {crc_valid_i, out_of_idle_flag_pin_out_i, crc_valid_flag_pin_out_i} <= 3'($random(seed));
    rx_ready_i <= !hold && ($random(seed) % 4 != 0);
  end
  // every delivered byte against the model
  always @(posedge core_clk_i) begin
    if (!sys_rst_i && rx_valid_o === 1'b1 && rx_ready_i)
      chk({rx_header_o, rx_data_o}, expq.size() ? expq.pop_front() : 9'h1ff);
  end
  always @(posedge core_clk_i) if (tx_req_o === 1'b1) load_byte();

  // --------------------------------------------------------
  // tasks
  // --------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : tick
  task automatic load_byte();
    #1;
    tx_data_i = 8'($random(seed));
    tx_load_i = 1'b1;
    txq.push_back(tx_data_i);
    @(posedge core_clk_i) #1 tx_load_i = 1'b0;
  endtask : load_byte
  task automatic wait_mode(input logic [2:0] m);
    for (int k = 0; k < 20 && mode_o !== m; k++) tick(1);
    chk(mode_o, m);
  endtask : wait_mode
  // second half period of the clock output, the first full one
  task automatic meas(input logic [2:0] c);
    int n;
    logic v;
    for (int k = 0; k < 2; k++) begin
      v = host_clock_out_o;
      n = 0;
      while (host_clock_out_o === v && n < 7000) begin
        tick(1);
        n++;
      end
    end
    chk(n, 100000000 / (2 * HZ[c]));
  endtask : meas
  // one transaction: header plus n data bytes
  task automatic frame(input bit rd, input int n);
    logic [7:0] b;
    logic [7:0] r;
    int gap;
    gap = ($random(seed) & 1) ? 90 : 0;
    host.open_frame();
    for (int i = 0; i <= n; i++) begin
      b = 8'($random(seed));
      if (i == 0) b[7] = rd;
      if (i == 0 || !rd) begin
        if (expq.size() < DEPTH + 2) expq.push_back({i == 0, b});
        else exp_ovr = 1'b1;
      end
      host.burst(b, rd && i > 0, gap, r);
      if (rd && i > 0) chk(r, txq.size() ? txq.pop_front() : 9'h1ff);
    end
    host.close_frame();
    for (int k = 0; k < 40 && frame_done_o !== 1'b1; k++) tick(1);
    chk(frame_done_o, 1);
    chk(frame_short_o, n < 2);
    tick(3);
  endtask : frame
  task automatic drain();
    for (int k = 0; k < 500 && expq.size() > 0; k++) tick(1);
    chk(expq.size(), 0);
  endtask : drain
  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  // --------------------------------------------------------
  // main sequence
  // --------------------------------------------------------
  initial begin
    tick(2);
    sys_rst_i = 1'b0;
    chip_reset_n_i = 1'b1;
    wait_mode(radio_spi_pkg::MODE_IDLE);
    meas(3'h6);
    load_byte();
    chk(tx_full_o, 1);
    for (int i = 0; i < 8; i++) frame(i[0], i / 2);
    drain();
    hold = 1'b1;
    tick(3);
    frame(1'b0, DEPTH - 1);
    tick(20);
    chk(rx_overrun_o, 0);
    frame(1'b0, 2);
    tick(20);
    chk(rx_overrun_o, exp_ovr);
    hold = 1'b0;
    drain();
    rx_overrun_clr_i = 1'b1;
    tick(1);
    rx_overrun_clr_i = 1'b0;
    tick(2);
    chk(rx_overrun_o, 0);
    gpio_alt_en_i = 1'b1;
    for (int t = 0; t < 2; t++) begin
      seq_tx_sel_i = t[0];
      radio_sequence_trigger_i = 1'b1;
      wait_mode(t ? radio_spi_pkg::MODE_TX : radio_spi_pkg::MODE_RX);
      tick(6);
      chk(out_of_idle_flag_pin_o, 1);
      radio_sequence_trigger_i = 1'b0;
      wait_mode(radio_spi_pkg::MODE_IDLE);
      sleep_hibernate_i = t[0];
      sleep_req_i = 1'b1;
      tick(1);
      sleep_req_i = 1'b0;
      wait_mode(t ? radio_spi_pkg::MODE_HIBERNATE : radio_spi_pkg::MODE_DOZE);
      wake_request_n_i = 1'b0;
      wait_mode(radio_spi_pkg::MODE_IDLE);
      tick(6);
      wake_request_n_i = 1'b1;
    end
    gpio_alt_en_i = 1'b0;
    for (int c = 0; c < 8; c++) begin
      host_clock_out_sel_i = c[2:0];
      host_clock_out_sel_we_i = 1'b1;
      tick(1);
      host_clock_out_sel_we_i = 1'b0;
      meas(c[2:0]);
    end
    chip_reset_n_i = 1'b0;
    tick(6);
    chk(mode_o, radio_spi_pkg::MODE_OFF);
    chk(host_clock_out_o, 0);
    chip_reset_n_i = 1'b1;
    wait_mode(radio_spi_pkg::MODE_IDLE);
    meas(3'h6);
    frame(1'b0, 2);
    drain();
    finish_test();
  end
endmodule : radio_spi_slave_host_port_tb
